// >>> logic/e1fs_pkg.sv
// Package for the E1 framing, sync and alarm block: map, fields, timing.
// Assumes a 40 MHz ref_clk and 32-bit APB data with byte addresses.
`default_nettype none
package e1fs_pkg;
	localparam int CLK_HZ = 40_000_000;
	localparam int RESYNC_MS = 8;
	localparam int IW_MS = 400;
	localparam int CRC_WIN_MS = 1000;
	localparam int RESYNC_CYC = CLK_HZ / 1000 * RESYNC_MS;
	localparam int IW_CYC = CLK_HZ / 1000 * IW_MS;
	localparam int CRC_WIN_CYC = CLK_HZ / 1000 * CRC_WIN_MS;
	// Register byte addresses
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_LINE = 8'h04;
	localparam logic [7:0] A_LOS = 8'h08;
	localparam logic [7:0] A_IMR = 8'h0C;
	localparam logic [7:0] A_STAT = 8'h10;
	localparam logic [7:0] A_EVT = 8'h14;
	localparam logic [7:0] A_CMD = 8'h18;
	localparam logic [7:0] A_CRC = 8'h1C;
	// Control field positions
	localparam int C_LSS = 0;
	localparam int C_RFS = 1;
	localparam int C_AFR = 3;
	localparam int C_ALMF = 4;
	localparam int C_AXRA = 5;
	localparam int C_EXTIW = 6;
	localparam int C_AXS = 7;
	localparam int C_EBP = 8;
	localparam int L_TXC = 0;
	localparam int L_RXC = 2;
	localparam int L_DRS = 4;
	localparam int L_CMI = 5;
	localparam int L_DIG = 6;
	localparam int K_RESTART = 0;
	localparam int K_CRCCLR = 1;
	localparam int EV_LOS = 0;
	localparam int EV_LFA = 1;
	localparam int EV_IW = 2;
	localparam int EV_RESYNC = 3;
	// Reset values
	localparam logic [8:0] CTRL_RST = 9'h000;
	localparam logic [6:0] LINE_RST = 7'h00;
	localparam logic [7:0] PC_RST = 8'h00;
	localparam logic [7:0] IMR_RST = 8'hFF;
	localparam logic [9:0] CRC_LIMIT = 10'h392;
	localparam int LOS_SPAN_SHIFT = 4;
	// Line code select values and framing select values
	localparam logic [1:0] SEL_NRZ = 2'h0;
	localparam logic [1:0] SEL_CMI = 2'h1;
	localparam logic [1:0] SEL_AMI = 2'h2;
	localparam logic [1:0] RFS_DF = 2'h0;
	localparam logic [1:0] RFS_AUTO = 2'h2;
	localparam logic [1:0] RFS_IW = 2'h3;
	typedef enum logic [2:0] {
		CODE_NRZ, CODE_AMI, CODE_HDB3, CODE_CMI, CODE_CMI_HDB3
	} e1fs_code_t;
	typedef enum logic [1:0] {
		FS_ASYNC, FS_DF_SYNC, FS_MF_SEARCH, FS_MF_SYNC
	} e1fs_state_t;
endpackage
`default_nettype wire

// >>> logic/e1fs_timer.sv
// Interval timer: counts while run is high, pulses expire every CYCLES.
// Assumes run drops whenever the interval must start again.
`default_nettype none
module e1fs_timer #(
	parameter int CYCLES = 320000
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Control and result
	input wire logic run,
	output logic expire
);
	localparam int CW = $clog2(CYCLES);
	logic [CW-1:0] cnt_r;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
			expire <= 1'b0;
		end else if (!run) begin
			cnt_r <= '0;
			expire <= 1'b0;
		end else begin
			expire <= (cnt_r == CW'(CYCLES - 1));
			cnt_r <= (cnt_r == CW'(CYCLES - 1)) ? '0 : cnt_r + 1'b1;
		end
	end

	timer_expiry_a: assert property (@(posedge ref_clk) disable iff (rst)
		expire |-> cnt_r == '0 && $past(run))
		else $error("timer expired off its count");
endmodule // e1fs_timer
`default_nettype wire

// >>> logic/e1fs_los.sv
// Loss-of-signal detector on the received bit stream.
// Assumes one received line bit per cycle in which bit_valid is high.
`default_nettype none
module e1fs_los
	import e1fs_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Received bits
	input wire logic bit_valid,
	input wire logic bit_in,
	// Pulse counts
	input wire logic [7:0] los_detect_pulse_count,
	input wire logic [7:0] los_recover_pulse_count,
	// Result
	output logic los
);
	logic [12:0] span;
	logic [12:0] zero_cnt_r;
	logic [12:0] win_cnt_r;
	logic [12:0] ones_cnt_r;

	// Detection interval is (count + 1) times 16 bits
	assign span = 13'(({5'h00, los_detect_pulse_count} + 13'h0001) << LOS_SPAN_SHIFT);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			zero_cnt_r <= '0;
		else if (bit_valid && bit_in)
			zero_cnt_r <= '0;
		else if (bit_valid && zero_cnt_r != 13'h1FFF)
			zero_cnt_r <= zero_cnt_r + 13'h0001;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			los <= 1'b0;
			win_cnt_r <= '0;
			ones_cnt_r <= '0;
		end else if (!los) begin
			win_cnt_r <= '0;
			ones_cnt_r <= '0;
			if (bit_valid && !bit_in && zero_cnt_r == span - 13'h0001)
				los <= 1'b1;
		end else if (bit_valid) begin
			if (bit_in && ones_cnt_r == {5'h00, los_recover_pulse_count})
				los <= 1'b0;
			if (win_cnt_r == span - 13'h0001) begin
				win_cnt_r <= '0;
				ones_cnt_r <= '0;
			end else begin
				win_cnt_r <= win_cnt_r + 13'h0001;
				ones_cnt_r <= ones_cnt_r + {12'h000, bit_in};
			end
		end
	end

	los_detect_a: assert property (@(posedge ref_clk) disable iff (rst)
		$rose(los) |-> $past(zero_cnt_r) == $past(span) - 13'h0001)
		else $error("loss of signal raised at wrong zero count");
	los_recover_a: assert property (@(posedge ref_clk) disable iff (rst)
		$fell(los) |-> $past(ones_cnt_r) == {5'h00, $past(los_recover_pulse_count)})
		else $error("loss of signal cleared at wrong ones count");
	zero_restart_a: assert property (@(posedge ref_clk) disable iff (rst)
		bit_valid && bit_in |=> zero_cnt_r == '0)
		else $error("zero run not restarted by a one");
endmodule // e1fs_los
`default_nettype wire

// >>> logic/e1fs_top.sv
// E1 receive sync control, alarm automation, line code and LOS with APB.
// Assumes the framer core reports alignment events as one-cycle pulses.
//
// The APB slave port and the register addresses were decided locally.
`default_nettype none

// Operation
// - Analog line uses AMI or HDB3; digital adds NRZ, CMI, CMI over HDB3.
// - Detect count 0A hex declares loss of signal after 176 zeros.
// - Recovery count 15 hex clears loss after 22 ones in the interval.
// - Auto E-bit puts received submultiframe CRC status in next multiframe.
// - In asynchronous state the E-bit follows the polarity control bit.
// - Auto remote alarm follows lost frame alignment, ends when regained.
// - Select 10 with auto resync restarts doubleframe search after 8 ms.
// - More than 914 CRC4 errors in one second restart the whole search.
// - Interworking keeps doubleframe after 400 ms and raises an event.
// - Extended interworking sends remote alarm, keeps searching, no 8 ms.
// - Control registers read back; command register is write only.
// - Reset comes up in E1 with doubleframe format.
// - Interrupt mask resets to FF hex, all sources disabled.
module e1fs_top
	import e1fs_pkg::*;
#(
	parameter int RESYNC_CYCLES = RESYNC_CYC,
	parameter int IW_CYCLES = IW_CYC,
	parameter int CRC_WIN_CYCLES = CRC_WIN_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Received line bits
	input wire logic rx_bit_valid,
	input wire logic rx_bit,
	// Framer core events
	input wire logic fas_found,
	input wire logic fas_lost,
	input wire logic mf_found,
	input wire logic crc4_err,
	input wire logic rx_mf_end,
	input wire logic [1:0] rx_smf_err,
	input wire logic tx_mf_start,
	// Control and alarm outputs
	output logic t1_mode,
	output e1fs_pkg::e1fs_code_t rx_code,
	output e1fs_pkg::e1fs_code_t tx_code,
	output logic los,
	output logic frame_alignment_lost_flag,
	output logic mf_sync,
	output logic rai_send,
	output logic [1:0] tx_ebit,
	output logic resync_req,
	output logic irq
);
	import e1fs_pkg::*;

	logic [8:0] ctrl_r;
	logic [6:0] line_r;
	logic [7:0] pcd_r;
	logic [7:0] pcr_r;
	logic [7:0] imr_r;
	logic [3:0] ev_r;
	logic [3:0] ev_set;
	logic [9:0] crc_cnt_r;
	logic [9:0] crc_last_r;
	logic [1:0] smf_err_r;
	logic los_d_r;
	logic iw_rai_r;
	logic [31:0] rd_mux;
	logic wr;
	logic cmd_restart;
	logic cmd_crcclr;
	logic t8_exp;
	logic t400_exp;
	logic win_exp;
	logic resync_nxt;
	logic iw_ev;
	logic [1:0] rfs;
	e1fs_state_t st_r;
	e1fs_state_t st_nxt;

	assign rfs = ctrl_r[C_RFS +: 2];
	assign wr = psel && penable && pready && pwrite;
	assign cmd_restart = wr && paddr == A_CMD && pwdata[K_RESTART];
	assign cmd_crcclr = wr && paddr == A_CMD && pwdata[K_CRCCLR];

	// APB: one wait-free access phase, read data latched in setup
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable)
				prdata <= pwrite ? 32'h0000_0000 : rd_mux;
		end
	end

	always_comb begin
		case (paddr)
			A_CTRL: rd_mux = {23'h000000, ctrl_r};
			A_LINE: rd_mux = {25'h0000000, line_r};
			A_LOS: rd_mux = {16'h0000, pcr_r, pcd_r};
			A_IMR: rd_mux = {24'h000000, imr_r};
			A_STAT: rd_mux = {26'h0000000, tx_ebit, rai_send, mf_sync,
				frame_alignment_lost_flag, los};
			A_EVT: rd_mux = {28'h0000000, ev_r};
			A_CRC: rd_mux = {22'h000000, crc_last_r};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Writable control registers; unused addresses take no effect
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_r <= CTRL_RST;
			line_r <= LINE_RST;
			pcd_r <= PC_RST;
			pcr_r <= PC_RST;
			imr_r <= IMR_RST;
		end else if (wr) begin
			case (paddr)
				A_CTRL: ctrl_r <= pwdata[8:0];
				A_LINE: line_r <= pwdata[6:0];
				A_LOS: begin
					pcd_r <= pwdata[7:0];
					pcr_r <= pwdata[15:8];
				end
				A_IMR: imr_r <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// Line standard select drives the T1/J1 mode strap of the core
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			t1_mode <= 1'b0;
		else
			t1_mode <= ctrl_r[C_LSS];
	end

	function automatic e1fs_code_t code_of(input logic [1:0] sel,
		input logic pre, input logic dig);
		e1fs_code_t c;
		case (sel)
			SEL_NRZ: c = CODE_NRZ;
			SEL_CMI: c = pre ? CODE_CMI_HDB3 : CODE_CMI;
			SEL_AMI: c = CODE_AMI;
			default: c = CODE_HDB3;
		endcase
		// The analog front end only carries the bipolar codes
		if (!dig && c != CODE_AMI)
			c = CODE_HDB3;
		return c;
	endfunction

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rx_code <= CODE_HDB3;
			tx_code <= CODE_HDB3;
		end else begin
			rx_code <= code_of(line_r[L_RXC +: 2], line_r[L_CMI],
				line_r[L_DIG] | line_r[L_DRS]);
			tx_code <= code_of(line_r[L_TXC +: 2], line_r[L_CMI],
				line_r[L_DIG] | line_r[L_DRS]);
		end
	end

	e1fs_los u_los (
		.ref_clk(ref_clk),
		.rst(rst),
		.bit_valid(rx_bit_valid),
		.bit_in(rx_bit),
		.los_detect_pulse_count(pcd_r),
		.los_recover_pulse_count(pcr_r),
		.los(los)
	);

	e1fs_timer #(.CYCLES(RESYNC_CYCLES)) u_t8 (
		.ref_clk(ref_clk),
		.rst(rst),
		.run(st_r == FS_MF_SEARCH && rfs == RFS_AUTO),
		.expire(t8_exp)
	);

	e1fs_timer #(.CYCLES(IW_CYCLES)) u_t400 (
		.ref_clk(ref_clk),
		.rst(rst),
		.run(st_r == FS_MF_SEARCH && rfs == RFS_IW && !iw_rai_r),
		.expire(t400_exp)
	);

	e1fs_timer #(.CYCLES(CRC_WIN_CYCLES)) u_win (
		.ref_clk(ref_clk),
		.rst(rst),
		.run(1'b1),
		.expire(win_exp)
	);

	// Receive synchronization sequence
	always_comb begin
		st_nxt = st_r;
		resync_nxt = 1'b0;
		iw_ev = 1'b0;
		case (st_r)
			FS_ASYNC:
				if (fas_found)
					st_nxt = (rfs == RFS_DF) ? FS_DF_SYNC : FS_MF_SEARCH;
			FS_DF_SYNC: ;
			FS_MF_SEARCH: begin
				if (mf_found) begin
					st_nxt = FS_MF_SYNC;
				end else if (t8_exp && rfs == RFS_AUTO && ctrl_r[C_AFR]) begin
					st_nxt = FS_ASYNC;
					resync_nxt = 1'b1;
				end else if (t400_exp && rfs == RFS_IW) begin
					iw_ev = 1'b1;
					if (!ctrl_r[C_EXTIW])
						st_nxt = FS_DF_SYNC;
				end
			end
			FS_MF_SYNC:
				if (win_exp && crc_cnt_r > CRC_LIMIT && ctrl_r[C_ALMF]) begin
					st_nxt = FS_ASYNC;
					resync_nxt = 1'b1;
				end
			default: st_nxt = FS_ASYNC;
		endcase
		if (fas_lost || cmd_restart)
			st_nxt = FS_ASYNC;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_r <= FS_ASYNC;
			resync_req <= 1'b0;
			frame_alignment_lost_flag <= 1'b1;
			mf_sync <= 1'b0;
		end else begin
			st_r <= st_nxt;
			resync_req <= resync_nxt;
			frame_alignment_lost_flag <= st_nxt == FS_ASYNC;
			mf_sync <= st_nxt == FS_MF_SYNC;
		end
	end

	// CRC4 errors per one-second window
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			crc_cnt_r <= '0;
			crc_last_r <= '0;
		end else if (cmd_crcclr) begin
			crc_cnt_r <= '0;
			crc_last_r <= '0;
		end else if (win_exp) begin
			crc_cnt_r <= {9'h000, crc4_err};
			crc_last_r <= crc_cnt_r;
		end else if (crc4_err && crc_cnt_r != 10'h3FF) begin
			crc_cnt_r <= crc_cnt_r + 10'h001;
		end
	end

	// Remote alarm: lost alignment, or extended interworking timeout
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			iw_rai_r <= 1'b0;
			rai_send <= 1'b0;
		end else begin
			if (st_r != FS_MF_SEARCH)
				iw_rai_r <= 1'b0;
			else if (iw_ev && ctrl_r[C_EXTIW])
				iw_rai_r <= 1'b1;
			rai_send <= (ctrl_r[C_AXRA] && st_r == FS_ASYNC) || iw_rai_r;
		end
	end

	// E-bits for the outgoing multiframe
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			smf_err_r <= 2'h0;
			tx_ebit <= 2'h3;
		end else begin
			if (rx_mf_end)
				smf_err_r <= rx_smf_err;
			if (st_r == FS_ASYNC)
				tx_ebit <= {2{ctrl_r[C_EBP]}};
			else if (tx_mf_start)
				tx_ebit <= ctrl_r[C_AXS] ? ~smf_err_r : 2'h3;
		end
	end

	// Sticky events, write one to clear; a new event wins over the clear
	assign ev_set = {resync_nxt, iw_ev,
		st_nxt == FS_ASYNC && st_r != FS_ASYNC, los && !los_d_r};

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			los_d_r <= 1'b0;
			ev_r <= '0;
			irq <= 1'b0;
		end else begin
			los_d_r <= los;
			if (wr && paddr == A_EVT)
				ev_r <= (ev_r & ~pwdata[3:0]) | ev_set;
			else
				ev_r <= ev_r | ev_set;
			irq <= |(ev_r & ~imr_r[3:0]);
		end
	end

	lfa_rai_a: assert property (@(posedge ref_clk) disable iff (rst)
		ctrl_r[C_AXRA] && st_r == FS_ASYNC |=> rai_send)
		else $error("remote alarm missing while alignment lost");
	ebit_async_a: assert property (@(posedge ref_clk) disable iff (rst)
		st_r == FS_ASYNC && !rst
		|=> tx_ebit == {2{$past(ctrl_r[C_EBP])}})
		else $error("E-bit in asynchronous state not per polarity");
	ebit_auto_a: assert property (@(posedge ref_clk) disable iff (rst)
		st_r != FS_ASYNC && tx_mf_start && ctrl_r[C_AXS]
		|=> tx_ebit == ~$past(smf_err_r))
		else $error("E-bits not taken from submultiframe status");
	resync_8ms_a: assert property (@(posedge ref_clk) disable iff (rst)
		st_r == FS_MF_SEARCH && t8_exp && rfs == RFS_AUTO
		&& ctrl_r[C_AFR] && !mf_found
		|=> st_r == FS_ASYNC && resync_req ##1 !resync_req)
		else $error("no doubleframe restart after multiframe timeout");
	crc_resync_a: assert property (@(posedge ref_clk) disable iff (rst)
		st_r == FS_MF_SYNC && win_exp && crc_cnt_r > CRC_LIMIT
		&& ctrl_r[C_ALMF] |=> st_r == FS_ASYNC && resync_req)
		else $error("no resync after CRC4 error burst");
	iw_stay_a: assert property (@(posedge ref_clk) disable iff (rst)
		st_r == FS_MF_SEARCH && t400_exp && rfs == RFS_IW
		&& !ctrl_r[C_EXTIW] && !mf_found && !fas_lost && !cmd_restart
		|=> st_r == FS_DF_SYNC && ev_r[EV_IW])
		else $error("interworking timeout not handled");
	ext_iw_a: assert property (@(posedge ref_clk) disable iff (rst)
		st_r == FS_MF_SEARCH && t400_exp && rfs == RFS_IW
		&& ctrl_r[C_EXTIW] && !mf_found && !fas_lost && !cmd_restart
		|=> st_r == FS_MF_SEARCH ##1 rai_send)
		else $error("extended interworking did not keep search");
	analog_code_a: assert property (@(posedge ref_clk) disable iff (rst)
		!line_r[L_DIG] && !line_r[L_DRS]
		|=> rx_code == CODE_AMI || rx_code == CODE_HDB3)
		else $error("analog line given a digital-only code");
	cmd_read_a: assert property (@(posedge ref_clk) disable iff (rst)
		psel && !penable && !pwrite && paddr == A_CMD
		|=> prdata == 32'h0000_0000)
		else $error("command register read back data");
	irq_mask_a: assert property (@(posedge ref_clk) disable iff (rst)
		(ev_r & ~imr_r[3:0]) == 4'h0 |=> !irq)
		else $error("interrupt raised by a masked source");
endmodule // e1fs_top
`default_nettype wire

// >>> tb/e1fs_line_model.sv
// Far-end line model: received bit stream and framer core event pulses.
// Assumes the bench calls its tasks from one process at a time.
`default_nettype none
module e1fs_line_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Line bits
	output logic rx_bit_valid,
	output logic rx_bit,
	// Framer events
	output logic fas_found,
	output logic fas_lost,
	output logic mf_found,
	output logic crc4_err,
	output logic rx_mf_end,
	output logic [1:0] rx_smf_err,
	output logic tx_mf_start
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		rx_bit_valid = 1'h0;
		rx_bit = 1'h1;
		{fas_found, fas_lost, mf_found, crc4_err, rx_mf_end, tx_mf_start} = 6'h00;
		rx_smf_err = 2'h0;
	end
	task send_bits(input int n, input logic v);
		repeat (n) begin
			@(posedge ref_clk);
			rx_bit_valid <= 1'h1;
			rx_bit <= v;
		end
		@(posedge ref_clk);
		rx_bit_valid <= 1'h0;
		// Idle line shows the inverse so a stale bit cannot pass for data
		rx_bit <= ~v;
	endtask
	// Bits of m: found, lost, mf found, crc error, mf end, tx mf start
	task ev(input logic [5:0] m, input logic [1:0] smf, input int n);
		repeat (n) begin
			@(posedge ref_clk);
			{fas_found, fas_lost, mf_found, crc4_err, rx_mf_end, tx_mf_start} <= m;
			rx_smf_err <= smf;
		end
		@(posedge ref_clk);
		{fas_found, fas_lost, mf_found, crc4_err, rx_mf_end, tx_mf_start} <= 6'h00;
		rx_smf_err <= ~smf;
	endtask
endmodule // e1fs_line_model
`default_nettype wire

// >>> tb/tb_e1_framer_sync_alarm_setup.sv
// Testbench: APB register tests, line codes, LOS, framing automation.
// Assumes the line model drives the receive side and framer events.
`default_nettype none
module tb_e1_framer_sync_alarm_setup;
	timeunit 1ns;
	timeprecision 100ps;
	import e1fs_pkg::*;
	localparam int RS = 20;
	localparam int IW = 50;
	localparam int CW = 2000;
	// Clock matches the master clock the design is built for
	logic ref_clk = 1'h0;
	logic rst = 1'h1;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, rx_bit_valid, rx_bit, fas_found, fas_lost;
	logic mf_found, crc4_err, rx_mf_end, tx_mf_start, t1_mode, los;
	logic frame_alignment_lost_flag, mf_sync, rai_send, resync_req, irq;
	logic [1:0] rx_smf_err, tx_ebit;
	e1fs_code_t rx_code, tx_code;
	int mismatches = 0, checks = 0, cyc = 0, n;
	logic [6:0] lv [8] = '{7'h00, 7'h0A, 7'h05, 7'h40, 7'h45, 7'h65, 7'h4F, 7'h5A};
	e1fs_code_t ec [8] = '{CODE_HDB3, CODE_AMI, CODE_HDB3, CODE_NRZ, CODE_CMI,
		CODE_CMI_HDB3, CODE_HDB3, CODE_AMI};
	always #12.5 ref_clk = ~ref_clk;
	e1fs_top #(.RESYNC_CYCLES(RS), .IW_CYCLES(IW), .CRC_WIN_CYCLES(CW)) uut (
		.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx_bit_valid(rx_bit_valid),
		.rx_bit(rx_bit), .fas_found(fas_found), .fas_lost(fas_lost),
		.mf_found(mf_found), .crc4_err(crc4_err), .rx_mf_end(rx_mf_end),
		.rx_smf_err(rx_smf_err), .tx_mf_start(tx_mf_start), .t1_mode(t1_mode),
		.rx_code(rx_code), .tx_code(tx_code), .los(los),
		.frame_alignment_lost_flag(frame_alignment_lost_flag),
		.mf_sync(mf_sync), .rai_send(rai_send), .tx_ebit(tx_ebit),
		.resync_req(resync_req), .irq(irq));
	e1fs_line_model line (
		.ref_clk(ref_clk), .rst(rst), .rx_bit_valid(rx_bit_valid),
		.rx_bit(rx_bit), .fas_found(fas_found), .fas_lost(fas_lost),
		.mf_found(mf_found), .crc4_err(crc4_err), .rx_mf_end(rx_mf_end),
		.rx_smf_err(rx_smf_err), .tx_mf_start(tx_mf_start));
	task summarize;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			summarize();
		end
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge ref_clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		// Request stands until pready is seen high at a rising edge
		do @(posedge ref_clk); while (pready !== 1'h1);
		r = prdata;
		chk("pslverr", pslverr, 32'h0);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(a, 1'h1, d, r);
	endtask
	task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		xfer(a, 1'h0, 32'h0, r);
		chk(nm, r, e);
	endtask
	task cw(input int k);
		repeat (k) @(negedge ref_clk);
	endtask
	initial begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'h0;
		rdchk("ctrl", A_CTRL, 32'h0);
		rdchk("imr", A_IMR, 32'hFF);
		chk("lfa", frame_alignment_lost_flag, 32'h1);
		chk("t1", t1_mode, 32'h0);
		$display("test reset done");
		wr(A_LOS, 32'h150A);
		rdchk("pc", A_LOS, 32'h150A);
		wr(A_CTRL, 32'h1FE);
		rdchk("ctrl", A_CTRL, 32'h1FE);
		rdchk("cmd", A_CMD, 32'h0);
		wr(8'h20, 32'h0);
		rdchk("ctrl", A_CTRL, 32'h1FE);
		chk("t1", t1_mode, 32'h0);
		for (int i = 0; i < 8; i++) begin
			wr(A_LINE, {25'h0, lv[i]});
			cw(2);
			chk("rxc", rx_code, ec[i]);
			chk("txc", tx_code, ec[i]);
		end
		$display("test registers done");
		wr(A_CTRL, 32'h0);
		line.send_bits(175, 1'h0);
		line.send_bits(1, 1'h1);
		line.send_bits(175, 1'h0);
		cw(1);
		chk("los", los, 32'h0);
		line.send_bits(1, 1'h0);
		cw(1);
		chk("los", los, 32'h1);
		chk("irq", irq, 32'h0);
		wr(A_IMR, 32'hFE);
		cw(2);
		chk("irq", irq, 32'h1);
		wr(A_EVT, 32'hF);
		cw(2);
		chk("irq", irq, 32'h0);
		line.send_bits(21, 1'h1);
		cw(1);
		chk("los", los, 32'h1);
		line.send_bits(1, 1'h1);
		cw(1);
		chk("los", los, 32'h0);
		$display("test los done");
		wr(A_CTRL, 32'h1AC);
		cw(2);
		chk("ebit", tx_ebit, 32'h3);
		chk("rai", rai_send, 32'h1);
		line.ev(6'h20, 2'h0, 1);
		cw(2);
		chk("lfa", frame_alignment_lost_flag, 32'h0);
		chk("rai", rai_send, 32'h0);
		n = 0;
		while (resync_req !== 1'h1 && n < 100) begin
			@(negedge ref_clk);
			n++;
		end
		chk("resync", (n >= RS - 2 && n <= RS + 4), 32'h1);
		cw(2);
		chk("lfa", frame_alignment_lost_flag, 32'h1);
		chk("rai", rai_send, 32'h1);
		wr(A_CTRL, 32'h0AC);
		cw(2);
		chk("ebit", tx_ebit, 32'h0);
		$display("test resync done");
		wr(A_CTRL, 32'h092);
		line.ev(6'h20, 2'h0, 1);
		line.ev(6'h08, 2'h0, 1);
		cw(1);
		chk("mfs", mf_sync, 32'h1);
		line.ev(6'h02, 2'h1, 1);
		line.ev(6'h01, 2'h0, 1);
		cw(1);
		chk("ebit", tx_ebit, 32'h2);
		wr(A_EVT, 32'hF);
		line.ev(6'h04, 2'h0, 2 * CW + 10);
		xfer(A_EVT, 1'h0, 32'h0, q);
		chk("crc evt", q[3], 32'h1);
		chk("lfa", frame_alignment_lost_flag, 32'h1);
		xfer(A_CRC, 1'h0, 32'h0, q);
		chk("crc cnt", q[9:0] > CRC_LIMIT, 32'h1);
		wr(A_CMD, 32'h2);
		rdchk("crc clr", A_CRC, 32'h0);
		$display("test crc done");
		wr(A_CTRL, 32'h006);
		wr(A_CMD, 32'h1);
		wr(A_EVT, 32'hF);
		line.ev(6'h20, 2'h0, 1);
		cw(IW + 10);
		xfer(A_EVT, 1'h0, 32'h0, q);
		chk("iw evt", q[2], 32'h1);
		line.ev(6'h08, 2'h0, 1);
		cw(2);
		chk("mfs", mf_sync, 32'h0);
		chk("lfa", frame_alignment_lost_flag, 32'h0);
		wr(A_CTRL, 32'h04E);
		wr(A_CMD, 32'h1);
		line.ev(6'h20, 2'h0, 1);
		n = 0;
		repeat (IW + 10) begin
			@(negedge ref_clk);
			if (resync_req === 1'h1)
				n++;
		end
		chk("no resync", n, 32'h0);
		chk("rai", rai_send, 32'h1);
		line.ev(6'h08, 2'h0, 1);
		cw(3);
		chk("mfs", mf_sync, 32'h1);
		chk("rai", rai_send, 32'h0);
		line.ev(6'h10, 2'h0, 1);
		cw(2);
		chk("lfa", frame_alignment_lost_flag, 32'h1);
		wr(A_CTRL, 32'h0);
		line.ev(6'h20, 2'h0, 1);
		line.ev(6'h08, 2'h0, 1);
		line.ev(6'h01, 2'h0, 1);
		cw(1);
		chk("lfa", frame_alignment_lost_flag, 32'h0);
		chk("mfs", mf_sync, 32'h0);
		chk("ebit", tx_ebit, 32'h3);
		$display("test interworking done");
		summarize();
	end
endmodule // tb_e1_framer_sync_alarm_setup
`default_nettype wire
